// File: bxe_exec.sv
// Functional notes
// - clear or set opcode forces only the selected bit; others and flags untouched.
// - test opcode reads selected bit; if one, next instruction runs normally.
// - tested bit zero discards fetched next instruction, runs no-operation instead.
// - test takes one cycle, two when skipping; set and clear take one.
`timescale 1ns/1ps
`default_nettype none
module bxe_exec (
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_b_i,
    input  wire bxe_pkg::bxe_instr_t          instr_i,
    output logic                              instr_ready_o,
    output logic [bxe_pkg::ADDR_W-1:0]        rf_raddr_o,
    input  wire logic [bxe_pkg::DATA_W-1:0]   rf_rdata_i,
    output bxe_pkg::bxe_wr_t                  rf_wr_o,
    output logic                              cycle_end_o,
    output logic                              skip_nop_o,
    output logic                              busy_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        bxe_pkg::bxe_phase_t     phase;
        logic                    active;
        logic                    skip_cyc;
        logic                    skip_pend;
        bxe_pkg::bxe_dec_t       dec;
        logic [bxe_pkg::DATA_W-1:0] data;
        bxe_pkg::bxe_wr_t        wr;
        logic                    cyc_end;
    } bxe_state_t;

    bxe_state_t        st_q;
    bxe_state_t        st_d;
    bxe_pkg::bxe_dec_t dec_w;

    bxe_decode u_decode (
        .word_i (instr_i.word),
        .dec_o  (dec_w)
    );

    // ---------------------------------------------------------------
    // phase sequencing
    // ---------------------------------------------------------------
    always_comb begin
        st_d         = st_q;
        st_d.wr.we   = 1'b0;
        st_d.cyc_end = 1'b0;
        unique case (st_q.phase)
            bxe_pkg::PH_DECODE: begin
                if (st_q.skip_pend && instr_i.valid) begin
                    // fetched word dropped, no-operation cycle runs
                    st_d.skip_cyc  = 1'b1;
                    st_d.skip_pend = 1'b0;
                    st_d.active    = 1'b1;
                    st_d.dec.op    = bxe_pkg::OP_OTHER;
                    st_d.phase     = bxe_pkg::PH_READ;
                end else if (instr_i.valid) begin
                    st_d.skip_cyc = 1'b0;
                    st_d.active   = 1'b1;
                    st_d.dec      = dec_w;
                    st_d.phase    = bxe_pkg::PH_READ;
                end
            end
            bxe_pkg::PH_READ: begin
                if (!st_q.skip_cyc) begin
                    st_d.data = rf_rdata_i;
                end
                st_d.phase = bxe_pkg::PH_PROCESS;
            end
            bxe_pkg::PH_PROCESS: begin
                if (!st_q.skip_cyc) begin
                    unique case (st_q.dec.op)
                        bxe_pkg::OP_CLEAR: st_d.data[st_q.dec.bit_sel] = 1'b0;
                        bxe_pkg::OP_SET:   st_d.data[st_q.dec.bit_sel] = 1'b1;
                        bxe_pkg::OP_TEST:
                            // bit one: next runs normally, zero: skip
                            st_d.skip_pend = ~st_q.data[st_q.dec.bit_sel];
                        bxe_pkg::OP_OTHER: st_d.data = st_q.data;
                    endcase
                end
                st_d.phase = bxe_pkg::PH_WRITE;
            end
            bxe_pkg::PH_WRITE: begin
                // only set or clear write back; test and skip cycle idle
                if (!st_q.skip_cyc && (st_q.dec.op == bxe_pkg::OP_CLEAR ||
                                       st_q.dec.op == bxe_pkg::OP_SET)) begin
                    st_d.wr.we   = 1'b1;
                    st_d.wr.addr = st_q.dec.addr;
                    st_d.wr.data = st_q.data;
                end
                st_d.cyc_end  = 1'b1;
                st_d.active   = 1'b0;
                st_d.skip_cyc = 1'b0;
                st_d.phase    = bxe_pkg::PH_DECODE;
            end
            default: begin
                st_d.phase = bxe_pkg::PHASE_RST;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            st_q <= '0;
            st_q.phase <= bxe_pkg::PHASE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign instr_ready_o = (st_q.phase == bxe_pkg::PH_DECODE);
    assign rf_raddr_o    = st_q.dec.addr;
    assign rf_wr_o       = st_q.wr;
    assign cycle_end_o   = st_q.cyc_end;
    assign skip_nop_o    = st_q.skip_cyc;
    assign busy_o        = st_q.active;

endmodule
`default_nettype wire

// File: bxe_pkg.sv
package bxe_pkg;

    // ---------------------------------------------------------------
    // encoding
    // ---------------------------------------------------------------
    localparam int         INSTR_W       = 14;
    localparam int         ADDR_W        = 7;
    localparam int         DATA_W        = 8;
    localparam int         BIT_SEL_W     = 3;
    localparam logic [1:0] CLASS_BIT     = 2'h1;
    localparam logic [1:0] SUB_CLEAR     = 2'h0;
    localparam logic [1:0] SUB_SET       = 2'h1;
    localparam logic [1:0] SUB_TEST_ZERO = 2'h2;
    localparam int         CLASS_MSB     = 13;
    localparam int         SUB_MSB       = 11;
    localparam int         BIT_MSB       = 9;
    localparam int         ADDR_MSB      = 6;

    // ---------------------------------------------------------------
    // phases and timing
    // ---------------------------------------------------------------
    localparam int         PHASES_PER_CYCLE = 4;
    localparam int         CYC_TEST_NOSKIP  = 1;
    localparam int         CYC_TEST_SKIP    = 2;
    localparam int         CYC_SET_CLEAR    = 1;

    typedef enum logic [3:0] {
        PH_DECODE  = 4'h1,
        PH_READ    = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE   = 4'h8
    } bxe_phase_t;

    typedef enum logic [2:0] {
        OP_OTHER = 3'h0,
        OP_CLEAR = 3'h1,
        OP_SET   = 3'h2,
        OP_TEST  = 3'h3
    } bxe_op_t;

    typedef struct packed {
        bxe_op_t                 op;
        logic [ADDR_W-1:0]       addr;
        logic [BIT_SEL_W-1:0]    bit_sel;
    } bxe_dec_t;

    typedef struct packed {
        logic                    valid;
        logic [INSTR_W-1:0]      word;
    } bxe_instr_t;

    typedef struct packed {
        logic                    we;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } bxe_wr_t;

    localparam bxe_phase_t PHASE_RST = PH_DECODE;

endpackage

// File: bxe_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bxe_decode (
    input  wire logic [bxe_pkg::INSTR_W-1:0] word_i,
    output bxe_pkg::bxe_dec_t                dec_o
);
    // ---------------------------------------------------------------
    // field split and opcode classification
    // ---------------------------------------------------------------
    always_comb begin
        dec_o.addr    = word_i[bxe_pkg::ADDR_MSB:0];
        dec_o.bit_sel = word_i[bxe_pkg::BIT_MSB:bxe_pkg::ADDR_MSB+1];
        dec_o.op      = bxe_pkg::OP_OTHER;
        if (word_i[bxe_pkg::CLASS_MSB:bxe_pkg::CLASS_MSB-1] == bxe_pkg::CLASS_BIT) begin
            unique case (word_i[bxe_pkg::SUB_MSB:bxe_pkg::SUB_MSB-1])
                bxe_pkg::SUB_CLEAR:     dec_o.op = bxe_pkg::OP_CLEAR;
                bxe_pkg::SUB_SET:       dec_o.op = bxe_pkg::OP_SET;
                bxe_pkg::SUB_TEST_ZERO: dec_o.op = bxe_pkg::OP_TEST;
                default:                dec_o.op = bxe_pkg::OP_OTHER;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: bxe_exec_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bxe_exec_sva (
    input wire logic                sys_clk_i,
    input wire logic                rst_b_i,
    input wire bxe_pkg::bxe_instr_t instr_i,
    input wire logic                instr_ready_o,
    input wire logic [6:0]          rf_raddr_o,
    input wire logic [7:0]          rf_rdata_i,
    input wire bxe_pkg::bxe_wr_t    rf_wr_o,
    input wire logic                cycle_end_o,
    input wire logic                skip_nop_o,
    input wire logic                busy_o
);
    logic       tk;
    logic [3:0] op;
    assign tk = instr_i.valid && instr_ready_o;
    assign op = instr_i.word[13:10];
    // expected skip of the next taken word, from the tested bit
    logic [13:0] w_q;
    logic        ph_q;
    logic        sk_q;
    logic        pend_q;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            w_q    <= '0;
            ph_q   <= 1'b0;
            sk_q   <= 1'b0;
            pend_q <= 1'b0;
        end else if (tk) begin
            w_q    <= instr_i.word;
            ph_q   <= 1'b1;
            sk_q   <= pend_q;
            pend_q <= 1'b0;
        end else if (ph_q) begin
            ph_q <= 1'b0;
            if (!sk_q && w_q[13:10] == 4'h6) begin
                pend_q <= ~rf_rdata_i[w_q[9:7]];
            end
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_cyc; tk |=> !instr_ready_o [*3] ##1 (instr_ready_o && cycle_end_o); endproperty
    a_cyc: assert property (p_cyc) else $error("cycle length wrong");
    property p_clr; tk && op == 4'h4 ##1 !skip_nop_o |-> ##3 rf_wr_o.we
        && rf_wr_o.addr == $past(instr_i.word[6:0], 4)
        && rf_wr_o.data == ($past(rf_rdata_i, 3) & ~(8'h01 << $past(instr_i.word[9:7], 4)));
    endproperty
    a_clr: assert property (p_clr) else $error("clear write wrong");
    property p_set; tk && op == 4'h5 ##1 !skip_nop_o |-> ##3 rf_wr_o.we
        && rf_wr_o.addr == $past(instr_i.word[6:0], 4)
        && rf_wr_o.data == ($past(rf_rdata_i, 3) | (8'h01 << $past(instr_i.word[9:7], 4)));
    endproperty
    a_set: assert property (p_set) else $error("set write wrong");
    property p_tst; tk && op == 4'h6 ##1 !skip_nop_o |-> ##3 !rf_wr_o.we && cycle_end_o;
    endproperty
    a_tst: assert property (p_tst) else $error("test cycle wrote");
    property p_nxt; tk |=> skip_nop_o == $past(pend_q); endproperty
    a_nxt: assert property (p_nxt) else $error("test outcome wrong");
    property p_oth; tk && instr_i.word[13:12] != 2'h1 |-> ##4 cycle_end_o && !rf_wr_o.we; endproperty
    a_oth: assert property (p_oth) else $error("idle opcode wrote");
    property p_we; rf_wr_o.we |-> cycle_end_o; endproperty
    a_we: assert property (p_we) else $error("write outside fourth phase");
    property p_sk; skip_nop_o |-> !rf_wr_o.we; endproperty
    a_sk: assert property (p_sk) else $error("write in skipped cycle");
    property p_skl; $rose(skip_nop_o) |-> skip_nop_o [*3] ##1 !skip_nop_o; endproperty
    a_skl: assert property (p_skl) else $error("skip cycle too short");
endmodule
bind bxe_exec bxe_exec_sva u_sva (.*);
`default_nettype wire

// File: bxe_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
module bxe_rf_model (
    input wire logic             sys_clk_i,
    input wire logic [6:0]       raddr_i,
    output logic [7:0]           rdata_o,
    input wire bxe_pkg::bxe_wr_t wr_i
);
    logic [7:0] mem [128];
    assign rdata_o = mem[raddr_i];
    always @(posedge sys_clk_i) if (wr_i.we) mem[wr_i.addr] <= wr_i.data;
endmodule
`default_nettype wire

// File: tb_bit_oriented_instruction_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bit_oriented_instruction_exec;
    typedef struct packed {logic [13:0] w; logic [7:0] ini; logic [7:0] ex; logic sk;} bxe_row_t;
    logic                sys_clk_i, rst_b_i, ready, cend, skip, busy, we, sk;
    logic [6:0]          raddr;
    logic [7:0]          rdata;
    bxe_pkg::bxe_instr_t instr;
    bxe_pkg::bxe_wr_t    wr;
    int                  bad_count = 0, checks = 0, n;
    bxe_row_t rows [8] = '{'{{2'h1,2'h0,3'h7,7'h15},8'hC7,8'h47,1'b0},
        '{{2'h1,2'h1,3'h7,7'h15},8'h0A,8'h8A,1'b0}, '{{2'h1,2'h0,3'h0,7'h7F},8'hFF,8'hFE,1'b0},
        '{{2'h1,2'h1,3'h0,7'h00},8'h00,8'h01,1'b0}, '{{2'h1,2'h2,3'h1,7'h0C},8'h02,8'h02,1'b0},
        '{{2'h1,2'h2,3'h1,7'h0C},8'hFD,8'hFD,1'b1}, '{{2'h1,2'h2,3'h7,7'h7F},8'h7F,8'h7F,1'b1},
        '{14'h0000,8'h55,8'h55,1'b0}};
    bxe_exec u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .instr_i(instr), .instr_ready_o(ready),
        .rf_raddr_o(raddr), .rf_rdata_i(rdata), .rf_wr_o(wr), .cycle_end_o(cend), .skip_nop_o(skip),
        .busy_o(busy));
    bxe_rf_model u_rf (.sys_clk_i(sys_clk_i), .raddr_i(raddr), .rdata_o(rdata), .wr_i(wr));
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tick;
        @(posedge sys_clk_i);
        #1;
    endtask
    task run(input logic [13:0] w);
        instr = '{1'b1, w};
        for (n = 0; n < 8 && ready !== 1'b1; n++) tick;
        tick;
        instr.valid = 1'b0;
        sk = skip;
        for (n = 0; n < 8 && cend !== 1'b1; n++) tick;
        if (cend !== 1'b1) begin
            bad_count++;
            final_report;
        end
        we = wr.we;
    endtask
    initial begin
        sys_clk_i = 0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        rst_b_i = 0;
        instr = '0;
        repeat (6) @(posedge sys_clk_i);
        #1 rst_b_i = 1;
        chk("rst_out", {4'h0, ready, busy, skip, wr.we}, 8'h08);
        foreach (rows[i]) begin
            u_rf.mem[rows[i].w[6:0]] = rows[i].ini;
            run(rows[i].w);
            chk("we", 8'(we), 8'(rows[i].w[13:11] == 3'b010));
            tick;
            chk("reg", u_rf.mem[rows[i].w[6:0]], rows[i].ex);
            run({2'h1, 2'h1, rows[i].w[9:7], rows[i].w[6:0]});
            chk("skip", 8'(sk), 8'(rows[i].sk));
            chk("next_we", 8'(we), 8'(!rows[i].sk));
            tick;
            chk("next_reg", u_rf.mem[rows[i].w[6:0]],
                rows[i].sk ? rows[i].ex : (rows[i].ex | (8'h01 << rows[i].w[9:7])));
            chk("skip_end", 8'(skip), 8'h00);
            $display("row %0d done", i);
        end
        u_rf.mem[7'h20] = 8'h00;
        run({2'h1, 2'h1, 3'h3, 7'h20});
        run({2'h1, 2'h1, 3'h5, 7'h20});
        tick;
        chk("b2b_reg", u_rf.mem[7'h20], 8'h28);
        $display("back to back done");
        instr = '{1'b1, {2'h1, 2'h1, 3'h0, 7'h21}};
        tick;
        rst_b_i = 0;
        instr.valid = 1'b0;
        tick;
        chk("rst_mid", {4'h0, ready, busy, skip, wr.we}, 8'h08);
        rst_b_i = 1;
        $display("reset test done");
        final_report;
    end
endmodule
`default_nettype wire
